//--- common/audio_regs_defs.svh
// Register offsets, field positions and reset values for the serial audio register block.
// Assumes a 16-bit byte address space with one 8-bit register per address.
`ifndef AUDIO_REGS_DEFS_SVH
`define AUDIO_REGS_DEFS_SVH

`define AUD_ADDR_W            16
`define AUD_OFF_CONFIG_LOW    16'hdf40
`define AUD_OFF_CONFIG_HIGH   16'hdf41
`define AUD_OFF_DATA_LOW      16'hdf42
`define AUD_OFF_DATA_HIGH     16'hdf43
`define AUD_OFF_WORD_COUNT    16'hdf44
`define AUD_OFF_STATUS        16'hdf45
`define AUD_OFF_DIVIDER_DENOMINATOR_LOW     16'hdf46
`define AUD_OFF_NUMER_LOW     16'hdf47
`define AUD_OFF_DIV_HIGH      16'hdf48

`define AUD_RST_DATA          8'h00
`define AUD_RST_WORD_COUNT    8'h00
`define AUD_RST_DIVIDER_DENOMINATOR_LOW     8'h93
`define AUD_RST_NUMER_LOW     8'he2
`define AUD_RST_DIVIDER_DENOMINATOR_HIGH    1'b0
`define AUD_RST_NUMER_HIGH    7'h04
`define AUD_RST_WORD_SIZE     5'h0f
`define AUD_RST_TRIG_SEL      2'h0

`define AUD_CFG_ENABLE_BIT    0
`define AUD_CFG_MASTER_BIT    1
`define AUD_CFG_TRIG_LSB      1
`define AUD_CFG_TRIG_MSB      2
`define AUD_CFG_WSIZE_LSB     3
`define AUD_CFG_WSIZE_MSB     7

`define AUD_ST_TX_UNDERFLOW   7
`define AUD_ST_RX_OVERFLOW    6
`define AUD_ST_TX_CHANNEL     5
`define AUD_ST_RX_CHANNEL     4
`define AUD_ST_TX_IRQ         3
`define AUD_ST_RX_IRQ         2
`define AUD_ST_CNT_HI_MSB     1

`define AUD_DIV_DIVIDER_DENOMINATOR_HI_BIT  7
`define AUD_DIV_NUMER_HI_MSB  6

`endif

//--- common/audio_regs_pkg.sv
// Types shared by the serial audio register block and its bench.
// Assumes the constants of audio_regs_defs.svh for all numeric values.
package audio_regs_pkg;

	typedef enum logic [1:0] {
		TRIG_REG_WRITE = 2'h0,
		TRIG_FRAME_SOF = 2'h1,
		TRIG_PIN_EVENT = 2'h2,
		TRIG_TIMER_EVT = 2'h3
	} trig_sel_t;

	typedef struct packed {
		logic sck;
		logic ws;
		logic sd;
	} link_in_t;

	typedef struct packed {
		logic sck;
		logic sck_oe;
		logic ws;
		logic ws_oe;
		logic sd;
	} link_out_t;

	typedef struct packed {
		logic sof;
		logic pin;
		logic timer;
	} trig_in_t;

endpackage

//--- hdl/audio_regs.sv
// Serial audio data, status and clock registers with a compact serializer behind them.
// Assumes a CPU on the plain register port and a codec on the link pins, all synchronous to
// i_ref_clk; trigger inputs are one-cycle pulses.
//
// Function
// R1 - Two data high writes without a low write clear the transmit low byte.
// R2 - Both data bytes return to zero on wake from deep sleep modes.
// R3 - Reading data high clears receive interrupt flag and empties receive buffer.
// R4 - Writing data high clears transmit interrupt flag (bit 3) and fills transmit buffer.
// R5 - Word count register shows low 8 bits of counter at last trigger.
// R6 - Status bits 1:0 show counter upper bits at last trigger; read-only, reset zero.
// R7 - Any word count write snapshots the live counter then clears it.
// R8 - Status bit 7 sets on transmit underflow; software writes zero to clear.
// R9 - Status bit 6 sets on receive overflow; software writes zero to clear.
// R10 - Status bit 5 shows channel to load next: zero left, one right.
// R11 - Status bit 4 shows channel of received word: zero left, one right.
// R12 - Status bit 2 receive flag: software may set, data high read clears.
// R13 - Denominator is 9 bits: low register plus divider high bit 7.
// R14 - Numerator is 15 bits: low register plus divider high bits 6:0.
// R15 - Master bit clock comes from a fractional divider of numerator over denominator.
// R16 - Transmit flag sets when buffer empties; receive flag sets on a received word.
// R17 - Master drives clock and word select; slave takes both from pins.
// R18 - Five-bit field holds sample length minus one, reset sixteen bits.
// R19 - Trigger select: register write, frame start, pin event, timer event.
// R20 - Enable bit activates the link; disabled, the serializer stays idle.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "audio_regs_defs.svh"

module audio_regs
	import audio_regs_pkg::*;
#(
	parameter int WORD_W = 16,
	parameter int CNT_W  = 10
)
(
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_wake,
	input  wire logic [`AUD_ADDR_W-1:0] i_addr,
	input  wire logic [7:0]             i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic      [7:0]             o_rdata,
	input  wire trig_in_t               i_trig,
	input  wire link_in_t               i_link,
	output link_out_t                   o_link
);

	generate
		if (WORD_W != 16 || CNT_W != 10)
		begin : g_check
			$error("audio_regs supports only a 16-bit data word and a 10-bit counter");
		end
	endgenerate

	// Register write and read decode.
	logic wr_cfg_lo, wr_cfg_hi, wr_dat_lo, wr_dat_hi, wr_word_counter_value, wr_stat;
	logic wr_den_lo, wr_num_lo, wr_div_hi, rd_dat_hi;
	assign wr_cfg_lo = i_wr && i_addr == `AUD_OFF_CONFIG_LOW;
	assign wr_cfg_hi = i_wr && i_addr == `AUD_OFF_CONFIG_HIGH;
	assign wr_dat_lo = i_wr && i_addr == `AUD_OFF_DATA_LOW;
	assign wr_dat_hi = i_wr && i_addr == `AUD_OFF_DATA_HIGH;
	assign wr_word_counter_value   = i_wr && i_addr == `AUD_OFF_WORD_COUNT;
	assign wr_stat   = i_wr && i_addr == `AUD_OFF_STATUS;
	assign wr_den_lo = i_wr && i_addr == `AUD_OFF_DIVIDER_DENOMINATOR_LOW;
	assign wr_num_lo = i_wr && i_addr == `AUD_OFF_NUMER_LOW;
	assign wr_div_hi = i_wr && i_addr == `AUD_OFF_DIV_HIGH;
	assign rd_dat_hi = i_rd && i_addr == `AUD_OFF_DATA_HIGH;

	// Configuration.
	logic            interface_enable_reg;
	logic            master_mode_reg;
	logic [4:0]      word_size_reg;
	trig_sel_t       snapshot_trigger_select_reg;
	logic [7:0]      divider_denominator_low_reg;
	logic [7:0]      divider_numerator_low_reg;
	logic [7:0]      divider_high_bits_reg;
	logic [8:0]      divider_denominator;
	logic [14:0]     divider_numerator;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			interface_enable_reg        <= 1'b0;
			master_mode_reg             <= 1'b0;
			word_size_reg               <= `AUD_RST_WORD_SIZE;
			snapshot_trigger_select_reg <= TRIG_REG_WRITE;
		end
		else
		begin
			if (wr_cfg_lo)
			begin
				interface_enable_reg <= i_wdata[`AUD_CFG_ENABLE_BIT];
				master_mode_reg      <= i_wdata[`AUD_CFG_MASTER_BIT];
			end
			if (wr_cfg_hi)
			begin
				word_size_reg <= i_wdata[`AUD_CFG_WSIZE_MSB:`AUD_CFG_WSIZE_LSB]; // R18
				snapshot_trigger_select_reg <=
					trig_sel_t'(i_wdata[`AUD_CFG_TRIG_MSB:`AUD_CFG_TRIG_LSB]); // R19
			end
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			divider_denominator_low_reg <= `AUD_RST_DIVIDER_DENOMINATOR_LOW;
			divider_numerator_low_reg   <= `AUD_RST_NUMER_LOW;
			divider_high_bits_reg       <= {`AUD_RST_DIVIDER_DENOMINATOR_HIGH, `AUD_RST_NUMER_HIGH};
		end
		else
		begin
			if (wr_den_lo)
				divider_denominator_low_reg <= i_wdata;
			if (wr_num_lo)
				divider_numerator_low_reg <= i_wdata;
			if (wr_div_hi)
				divider_high_bits_reg <= i_wdata;
		end
	end

	assign divider_denominator = {divider_high_bits_reg[`AUD_DIV_DIVIDER_DENOMINATOR_HI_BIT],
		divider_denominator_low_reg}; // R13
	assign divider_numerator = {divider_high_bits_reg[`AUD_DIV_NUMER_HI_MSB:0],
		divider_numerator_low_reg}; // R14

	// Fractional divider: the half period of the bit clock is numerator/denominator system
	// clocks. A numerator below the denominator would need more than one toggle per cycle,
	// so the toggle rate then saturates at one per cycle.
	logic [15:0] frac_acc_reg;
	logic [15:0] frac_sum;
	logic        frac_toggle;
	logic        master_sck_reg;
	logic        link_active;
	assign link_active = interface_enable_reg; // R20
	assign frac_sum    = frac_acc_reg + {7'h00, divider_denominator};
	assign frac_toggle = frac_sum >= {1'b0, divider_numerator};

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || !link_active || !master_mode_reg)
		begin
			frac_acc_reg   <= 16'h0000;
			master_sck_reg <= 1'b0;
		end
		else if (frac_toggle)
		begin
			frac_acc_reg   <= frac_sum - {1'b0, divider_numerator}; // R15
			master_sck_reg <= ~master_sck_reg; // R15
		end
		else
			frac_acc_reg <= frac_sum;
	end

	// Bit clock edges, from the divider in master mode or from the pin in slave mode.
	logic sck_now, sck_prev_reg, sck_rise, sck_fall;
	assign sck_now = master_mode_reg ? master_sck_reg : i_link.sck; // R17

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			sck_prev_reg <= 1'b0;
		else
			sck_prev_reg <= sck_now;
	end

	assign sck_rise = link_active && sck_now && !sck_prev_reg;
	assign sck_fall = link_active && !sck_now && sck_prev_reg;

	// Word select: counted out in master mode, taken from the pin in slave mode.
	logic       master_ws_reg;
	logic [4:0] bit_cnt_reg;
	logic       ws_now, ws_seen_reg, ws_change;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || !link_active)
		begin
			master_ws_reg <= 1'b0;
			bit_cnt_reg   <= 5'h00;
		end
		else if (sck_fall && master_mode_reg)
		begin
			if (bit_cnt_reg >= word_size_reg)
			begin
				bit_cnt_reg   <= 5'h00;
				master_ws_reg <= ~master_ws_reg; // R18
			end
			else
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	assign ws_now    = master_mode_reg ? master_ws_reg : i_link.ws; // R17
	assign ws_change = sck_fall && ws_now != ws_seen_reg;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || !link_active)
			ws_seen_reg <= 1'b0;
		else if (sck_fall)
			ws_seen_reg <= ws_now;
	end

	// Transmit holding register and shifter.
	logic [7:0]        tx_low_reg, tx_high_reg;
	logic              tx_full_reg, low_written_reg;
	logic [WORD_W-1:0] tx_shift_reg;
	logic              tx_load, tx_empty_event, tx_underflow_event;
	assign tx_load            = ws_change;
	assign tx_empty_event     = tx_load && tx_full_reg;
	assign tx_underflow_event = tx_load && !tx_full_reg;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || i_wake)
		begin
			tx_low_reg  <= `AUD_RST_DATA; // R2
			tx_high_reg <= `AUD_RST_DATA; // R2
		end
		else if (wr_dat_lo)
			tx_low_reg <= i_wdata;
		else if (wr_dat_hi)
		begin
			tx_high_reg <= i_wdata;
			if (!low_written_reg)
				tx_low_reg <= `AUD_RST_DATA; // R1
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			low_written_reg <= 1'b0;
		else if (wr_dat_lo)
			low_written_reg <= 1'b1;
		else if (wr_dat_hi)
			low_written_reg <= 1'b0;
	end

	// A high-byte write in the same cycle as a load refills the buffer, so the write wins.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			tx_full_reg <= 1'b0;
		else if (wr_dat_hi)
			tx_full_reg <= 1'b1; // R4
		else if (tx_load)
			tx_full_reg <= 1'b0;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || !link_active)
			tx_shift_reg <= '0;
		else if (tx_load)
			tx_shift_reg <= {tx_high_reg, tx_low_reg};
		else if (sck_fall)
			tx_shift_reg <= {tx_shift_reg[WORD_W-2:0], 1'b0};
	end

	// Receive shifter and holding buffer.
	logic [WORD_W-1:0] rx_shift_reg, rx_hold_reg;
	logic              rx_full_reg, rx_word_event;
	assign rx_word_event = ws_change;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || !link_active)
			rx_shift_reg <= '0;
		else if (sck_rise)
			rx_shift_reg <= {rx_shift_reg[WORD_W-2:0], i_link.sd};
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || i_wake)
			rx_hold_reg <= {`AUD_RST_DATA, `AUD_RST_DATA}; // R2
		else if (rx_word_event)
			rx_hold_reg <= rx_shift_reg;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			rx_full_reg <= 1'b0;
		else if (rx_word_event)
			rx_full_reg <= 1'b1;
		else if (rd_dat_hi)
			rx_full_reg <= 1'b0; // R3
	end

	// Status flags; a hardware set always wins over a clear in the same cycle.
	logic tx_underflow_flag_reg, rx_overflow_flag_reg;
	logic tx_next_channel_reg, rx_current_channel_reg;
	logic tx_irq_pending_reg, rx_irq_pending_reg;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			tx_underflow_flag_reg <= 1'b0;
			rx_overflow_flag_reg  <= 1'b0;
		end
		else
		begin
			if (tx_underflow_event)
				tx_underflow_flag_reg <= 1'b1; // R8
			else if (wr_stat)
				tx_underflow_flag_reg <= i_wdata[`AUD_ST_TX_UNDERFLOW]; // R8
			if (rx_word_event && rx_full_reg)
				rx_overflow_flag_reg <= 1'b1; // R9
			else if (wr_stat)
				rx_overflow_flag_reg <= i_wdata[`AUD_ST_RX_OVERFLOW]; // R9
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			tx_next_channel_reg    <= 1'b0;
			rx_current_channel_reg <= 1'b0;
		end
		else
		begin
			if (tx_load)
				tx_next_channel_reg <= ~ws_now; // R10
			if (rx_word_event)
				rx_current_channel_reg <= ws_seen_reg; // R11
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			tx_irq_pending_reg <= 1'b0;
			rx_irq_pending_reg <= 1'b0;
		end
		else
		begin
			if (tx_empty_event || (wr_stat && i_wdata[`AUD_ST_TX_IRQ]))
				tx_irq_pending_reg <= 1'b1; // R16
			else if (wr_dat_hi)
				tx_irq_pending_reg <= 1'b0; // R4
			if (rx_word_event || (wr_stat && i_wdata[`AUD_ST_RX_IRQ]))
				rx_irq_pending_reg <= 1'b1; // R12
			else if (rd_dat_hi)
				rx_irq_pending_reg <= 1'b0; // R3
		end
	end

	// Word counter, one count per word loaded for transmission, with trigger snapshot.
	logic [CNT_W-1:0] word_counter_value_reg, word_count_snapshot_reg;
	logic             snap_trigger;

	always_comb
	begin
		snap_trigger = wr_word_counter_value; // R7
		case (snapshot_trigger_select_reg) // R19
			TRIG_FRAME_SOF: snap_trigger = wr_word_counter_value || i_trig.sof;
			TRIG_PIN_EVENT: snap_trigger = wr_word_counter_value || i_trig.pin;
			TRIG_TIMER_EVT: snap_trigger = wr_word_counter_value || i_trig.timer;
			default:        snap_trigger = wr_word_counter_value;
		endcase
	end

	// A word loaded in the trigger cycle is counted into the fresh count, not lost.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			word_counter_value_reg  <= '0;
			word_count_snapshot_reg <= '0;
		end
		else if (snap_trigger)
		begin
			word_count_snapshot_reg <= word_counter_value_reg; // R7
			word_counter_value_reg  <= tx_load ? {{(CNT_W-1){1'b0}}, 1'b1} : '0; // R7
		end
		else if (tx_load)
			word_counter_value_reg <= word_counter_value_reg + 1'b1;
	end

	// Read port: data stand in the cycle after the read strobe, zero elsewhere.
	logic [7:0] status_view;
	assign status_view = {tx_underflow_flag_reg, rx_overflow_flag_reg, tx_next_channel_reg,
		rx_current_channel_reg, tx_irq_pending_reg, rx_irq_pending_reg,
		word_count_snapshot_reg[CNT_W-1:8]}; // R6

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || !i_rd)
			o_rdata <= 8'h00;
		else if (i_addr == `AUD_OFF_CONFIG_LOW)
			o_rdata <= {6'h00, master_mode_reg, interface_enable_reg};
		else if (i_addr == `AUD_OFF_CONFIG_HIGH)
			o_rdata <= {word_size_reg, snapshot_trigger_select_reg, 1'b0};
		else if (i_addr == `AUD_OFF_DATA_LOW)
			o_rdata <= rx_hold_reg[7:0];
		else if (i_addr == `AUD_OFF_DATA_HIGH)
			o_rdata <= rx_hold_reg[15:8];
		else if (i_addr == `AUD_OFF_WORD_COUNT)
			o_rdata <= word_count_snapshot_reg[7:0]; // R5
		else if (i_addr == `AUD_OFF_STATUS)
			o_rdata <= status_view;
		else if (i_addr == `AUD_OFF_DIVIDER_DENOMINATOR_LOW)
			o_rdata <= divider_denominator_low_reg;
		else if (i_addr == `AUD_OFF_NUMER_LOW)
			o_rdata <= divider_numerator_low_reg;
		else if (i_addr == `AUD_OFF_DIV_HIGH)
			o_rdata <= divider_high_bits_reg;
		else
			o_rdata <= 8'h00;
	end

	// Link outputs. The data bit is registered and follows the shifter MSB.
	logic sd_out_reg;
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			sd_out_reg <= 1'b0;
		else
			sd_out_reg <= tx_shift_reg[WORD_W-1];
	end

	assign o_link.sck    = master_sck_reg;
	assign o_link.sck_oe = link_active && master_mode_reg; // R17
	assign o_link.ws     = master_ws_reg;
	assign o_link.ws_oe  = link_active && master_mode_reg; // R17
	assign o_link.sd     = sd_out_reg;

endmodule

//--- sim/audio_regs_checker.sv
// Port-level checker for audio_regs, bound into every instance.
// Assumes one clock domain and the register map of audio_regs_defs.svh.
`timescale 1ns/1ps
`include "audio_regs_defs.svh"
module audio_regs_checker
	import audio_regs_pkg::*;
(
	input wire logic                   i_ref_clk,
	input wire logic                   i_rst,
	input wire logic                   i_wake,
	input wire logic [`AUD_ADDR_W-1:0] i_addr,
	input wire logic [7:0]             i_wdata,
	input wire logic                   i_wr,
	input wire logic                   i_rd,
	input wire logic [7:0]             o_rdata,
	input wire link_in_t               i_link,
	input wire link_out_t              o_link
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	logic       ws_prev_reg;
	logic [2:0] still_reg;
	logic       quiet;

	// Flag checks need a link with no word boundary nearby, since hardware sets win.
	always_ff @(posedge i_ref_clk)
	begin
		ws_prev_reg <= i_link.ws;
	end
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || ws_prev_reg != i_link.ws)
			still_reg <= 3'h0;
		else if (still_reg != 3'h7)
			still_reg <= still_reg + 3'h1;
	end
	assign quiet = still_reg[2] && !o_link.sck_oe;

	a_oe_pair: assert property (o_link.sck_oe == o_link.ws_oe)
		else $error("clock and word select enables differ");
	a_tx_irq_pending_clear: assert property (i_wr && i_addr == `AUD_OFF_DATA_HIGH ##1
		i_rd && i_addr == `AUD_OFF_STATUS && quiet |=> !o_rdata[3])
		else $error("transmit flag not cleared by data high write");
	a_rx_irq_pending_clear: assert property (i_rd && i_addr == `AUD_OFF_DATA_HIGH ##1
		i_rd && i_addr == `AUD_OFF_STATUS && quiet |=> !o_rdata[2])
		else $error("receive flag not cleared by data high read");
	a_word_counter_value_low: assert property (i_wr && i_addr == `AUD_OFF_WORD_COUNT ##1
		i_wr && i_addr == `AUD_OFF_WORD_COUNT ##1
		i_rd && i_addr == `AUD_OFF_WORD_COUNT && quiet |=> o_rdata == 8'h00)
		else $error("word count not cleared by snapshot");
	a_word_counter_value_high: assert property (i_wr && i_addr == `AUD_OFF_WORD_COUNT ##1
		i_wr && i_addr == `AUD_OFF_WORD_COUNT ##1
		i_rd && i_addr == `AUD_OFF_STATUS && quiet |=> o_rdata[1:0] == 2'h0)
		else $error("upper count bits not cleared");
	a_wake_clear: assert property (i_wake ##1 i_rd && quiet &&
		i_addr inside {`AUD_OFF_DATA_LOW, `AUD_OFF_DATA_HIGH} |=> o_rdata == 8'h00)
		else $error("data byte not zero after wake");
	a_status_set: assert property (i_wr && i_addr == `AUD_OFF_STATUS ##1
		i_rd && i_addr == `AUD_OFF_STATUS |=>
		(o_rdata & $past(i_wdata, 2) & 8'hcc) == ($past(i_wdata, 2) & 8'hcc))
		else $error("status bit written one reads zero");
	a_div_readback: assert property (i_wr &&
		i_addr inside {`AUD_OFF_DIVIDER_DENOMINATOR_LOW, `AUD_OFF_NUMER_LOW, `AUD_OFF_DIV_HIGH} ##1
		i_rd && i_addr == $past(i_addr) |=> o_rdata == $past(i_wdata, 2))
		else $error("divider register readback differs");

	c_master: cover property (o_link.ws_oe && $changed(o_link.ws));
	c_slave: cover property (!o_link.sck_oe && $changed(i_link.ws));
	c_wake: cover property (i_wake);
endmodule

bind audio_regs audio_regs_checker i_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
	.i_wake(i_wake), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_link(i_link), .o_link(o_link));

//--- sim/codec_model.sv
// Codec model on the serial audio link: clock source when run is high, data source always.
// Assumes the block's link pins and the shared system clock.
`timescale 1ns/1ps
module codec_model
	import audio_regs_pkg::*;
(
	input  wire logic      i_ref_clk,
	input  wire logic      i_run,
	input  wire link_out_t i_link,
	output link_in_t       o_link
);
	logic [7:0]  ph_reg  = 8'h00;
	logic [15:0] pat_reg = 16'ha5c3;
	logic        sck_reg = 1'b0;
	logic        sck;

	// Stops only on a half-frame boundary, so the clock stands still between whole words.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_run || ph_reg[6:0] != 7'h00)
			ph_reg <= ph_reg + 8'h01;
	end
	assign sck = i_link.sck_oe ? i_link.sck : o_link.sck;
	// Only while the clock stands still does the data line run free, so a stale bit cannot
	// pass for data and a word that ends after run drops stays one unbroken stream.
	always_ff @(posedge i_ref_clk)
	begin
		sck_reg <= sck;
		if ((sck_reg && !sck) || (!i_run && ph_reg[6:0] == 7'h00 && !i_link.sck_oe))
			pat_reg <= {pat_reg[14:0], pat_reg[15]};
	end
	assign o_link.sck = ph_reg[2];
	assign o_link.ws  = ph_reg[7];
	assign o_link.sd  = pat_reg[15];
endmodule

//--- sim/audio_regs_tb.sv
// Self-checking bench for audio_regs: register tasks, master and slave traffic, triggers.
// Assumes the codec model on the link and the checker bound to the design.
`timescale 1ns/1ps
`include "audio_regs_defs.svh"
module audio_regs_tb
	import audio_regs_pkg::*;
;
	logic        i_ref_clk = 1'b0;
	logic        i_rst     = 1'b1;
	logic        i_wake    = 1'b0;
	logic [15:0] i_addr    = 16'h0000;
	logic [7:0]  i_wdata   = 8'h00;
	logic        i_wr      = 1'b0;
	logic        i_rd      = 1'b0;
	trig_in_t    i_trig    = '0;
	logic [7:0]  o_rdata;
	link_in_t    i_link;
	link_out_t   o_link;
	logic        run       = 1'b0;
	logic        chk_pend  = 1'b0;
	logic [7:0]  chk_exp   = 8'h00;
	logic [7:0]  chk_msk   = 8'h00;
	logic [31:0] seed      = 32'h0001_2725;
	logic        sck_m     = 1'b0;
	logic        ws_m      = 1'b0;
	logic        ws_s      = 1'b0;
	logic [15:0] sd_cap    = 16'h0000;
	logic [15:0] rd_word   = 16'h0000;
	int          miscompares = 0;
	int          n_tests     = 0;
	int          cyc, cnt, last_sck, last_ws, sck_gap, ws_gap;

	audio_regs i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wake(i_wake), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_trig(i_trig),
		.i_link(i_link), .o_link(o_link));
	codec_model i_codec (.i_ref_clk(i_ref_clk), .i_run(run), .i_link(o_link), .o_link(i_link));

	always #20 i_ref_clk = ~i_ref_clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// Read-only bits read zero; flags 3 and 2 only set on a written one.
	function automatic logic [7:0] st_exp(input logic [7:0] w, old);
		return (w & 8'hc0) | ((w | old) & 8'h0c);
	endfunction

	// True when v is some rotation of p; the phase of a serial stream is not tracked.
	function automatic logic is_rot(input logic [15:0] v, p);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			hit = hit | (v == p);
			p = {p[14:0], p[15]};
		end
		return hit;
	endfunction

	task automatic cmp(input logic [15:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Strobes are never lowered here, so operations follow each other with no gap.
	task automatic bus(input logic w, r, input logic [15:0] a, input logic [7:0] d,
		input logic [2:0] t, input logic [7:0] e, m);
		i_wr <= w;
		i_rd <= r;
		i_addr <= a;
		i_wdata <= d;
		i_trig <= trig_in_t'(t);
		@(posedge i_ref_clk);
		chk_pend <= r;
		chk_exp <= e;
		chk_msk <= m;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d, 3'h0, 8'h00, 8'h00);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e, m);
		bus(1'b0, 1'b1, a, 8'h00, 3'h0, e, m);
	endtask
	task automatic nop(input int n);
		repeat (n) bus(1'b0, 1'b0, 16'h0000, 8'h00, 3'h0, 8'h00, 8'h00);
	endtask

	always @(negedge i_ref_clk)
	begin
		cyc++;
		if (chk_pend)
		begin
			rd_word = {o_rdata, rd_word[15:8]};
			if (chk_msk != 8'h00)
				cmp({8'h00, o_rdata & chk_msk}, {8'h00, chk_exp});
		end
		if (o_link.sck_oe && o_link.sck && !sck_m)
			sd_cap = {sd_cap[14:0], o_link.sd};
		if (o_link.sck_oe && o_link.sck != sck_m)
		begin
			sck_gap = cyc - last_sck;
			last_sck = cyc;
		end
		if (o_link.ws_oe && o_link.ws != ws_m)
		begin
			ws_gap = cyc - last_ws;
			last_ws = cyc;
			cnt++;
		end
		if (i_link.ws != ws_s)
			cnt++;
		sck_m = o_link.sck;
		ws_m = o_link.ws;
		ws_s = i_link.ws;
	end

	initial
	begin : main
		logic [15:0] ra [9] = '{`AUD_OFF_DATA_LOW, `AUD_OFF_DATA_HIGH, `AUD_OFF_WORD_COUNT,
			`AUD_OFF_STATUS, `AUD_OFF_DIVIDER_DENOMINATOR_LOW, `AUD_OFF_NUMER_LOW, `AUD_OFF_DIV_HIGH,
			`AUD_OFF_CONFIG_HIGH, 16'hdf49};
		logic [7:0] re [9] = '{`AUD_RST_DATA, `AUD_RST_DATA, `AUD_RST_WORD_COUNT, 8'h00,
			`AUD_RST_DIVIDER_DENOMINATOR_LOW, `AUD_RST_NUMER_LOW, {`AUD_RST_DIVIDER_DENOMINATOR_HIGH, `AUD_RST_NUMER_HIGH},
			{`AUD_RST_WORD_SIZE, `AUD_RST_TRIG_SEL, 1'b0}, 8'h00};
		logic [2:0] sel;
		logic [15:0] tx_w;
		int k;
		repeat (12) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		for (int i = 0; i < 9; i++)
			rd(ra[i], re[i], 8'hff);
		for (int i = 0; i < 24; i++)
		begin
			seed = xs(seed);
			k = 4 + int'(seed[20:19]) % 3;
			wr(ra[k], seed[7:0]);
			rd(ra[k], seed[7:0], 8'hff);
		end
		wr(`AUD_OFF_DIVIDER_DENOMINATOR_LOW, 8'h01);
		wr(`AUD_OFF_NUMER_LOW, 8'h04);
		wr(`AUD_OFF_DIV_HIGH, 8'h00);
		wr(`AUD_OFF_STATUS, 8'hff);
		rd(`AUD_OFF_STATUS, st_exp(8'hff, 8'h00), 8'hff);
		wr(`AUD_OFF_STATUS, 8'h00);
		rd(`AUD_OFF_STATUS, st_exp(8'h00, 8'hcc), 8'hff);
		wr(`AUD_OFF_DATA_LOW, seed[15:8]);
		wr(`AUD_OFF_DATA_HIGH, seed[23:16]);
		rd(`AUD_OFF_STATUS, 8'h04, 8'hff);
		rd(`AUD_OFF_DATA_HIGH, 8'h00, 8'hff);
		rd(`AUD_OFF_STATUS, 8'h00, 8'hff);
		for (int i = 0; i < 2; i++)
		begin
			wr(`AUD_OFF_WORD_COUNT, seed[7:0]);
			wr(`AUD_OFF_WORD_COUNT, seed[15:8]);
			rd(i ? `AUD_OFF_STATUS : `AUD_OFF_WORD_COUNT, 8'h00, i ? 8'h03 : 8'hff);
		end
		for (int t = 0; t < 4; t++)
		begin
			sel = t ? 3'b100 >> (t - 1) : 3'b000;
			wr(`AUD_OFF_CONFIG_HIGH, 8'h78 | 8'(t << 1));
			wr(`AUD_OFF_WORD_COUNT, 8'h00);
			cnt = 0;
			if (t == 3)
				wr(`AUD_OFF_DATA_HIGH, seed[23:16]);
			wr(`AUD_OFF_CONFIG_LOW, 8'h03);
			nop(300);
			rd(`AUD_OFF_STATUS, 8'h30, 8'h30);
			nop(399);
			cmp({15'h0000, o_link.sck_oe}, 16'h0001);
			cmp(16'(sck_gap), 16'h0004);
			cmp(16'(ws_gap), 16'h0080);
			tx_w = {seed[23:16], ((t == 3) ? 8'h00 : seed[15:8])};
			cmp(16'(is_rot(sd_cap, tx_w)), 16'h0001);
			wr(`AUD_OFF_CONFIG_LOW, 8'h00);
			if (t == 0)
				wr(`AUD_OFF_WORD_COUNT, 8'h00);
			else
				bus(1'b0, 1'b0, 16'h0000, 8'h00, sel, 8'h00, 8'h00);
			bus(1'b0, 1'b0, 16'h0000, 8'h00, ~sel, 8'h00, 8'h00);
			rd(`AUD_OFF_WORD_COUNT, 8'(cnt), 8'hff);
			rd(`AUD_OFF_STATUS, 8'(cnt >> 8), 8'h03);
		end
		rd(`AUD_OFF_STATUS, 8'hcc, 8'hcc);
		wr(`AUD_OFF_STATUS, 8'h00);
		rd(`AUD_OFF_STATUS, 8'h00, 8'hc0);
		wr(`AUD_OFF_CONFIG_HIGH, 8'h78);
		wr(`AUD_OFF_WORD_COUNT, 8'h00);
		cnt = 0;
		wr(`AUD_OFF_CONFIG_LOW, 8'h01);
		run <= 1'b1;
		nop(600);
		cmp({15'h0000, o_link.sck_oe}, 16'h0000);
		run <= 1'b0;
		nop(200);
		wr(`AUD_OFF_CONFIG_LOW, 8'h00);
		wr(`AUD_OFF_WORD_COUNT, 8'h00);
		rd(`AUD_OFF_WORD_COUNT, 8'(cnt), 8'hff);
		rd(`AUD_OFF_DATA_LOW, 8'h00, 8'h00);
		rd(`AUD_OFF_DATA_HIGH, 8'h00, 8'h00);
		i_wake <= 1'b1;
		nop(1);
		cmp(16'(is_rot(rd_word, 16'ha5c3)), 16'h0001);
		i_wake <= 1'b0;
		rd(`AUD_OFF_DATA_LOW, 8'h00, 8'hff);
		rd(`AUD_OFF_DATA_HIGH, 8'h00, 8'hff);
		nop(2);
		final_report;
	end

	// The full sequence needs about 4000 cycles; the limit leaves ample margin.
	initial
	begin
		repeat (20000) @(posedge i_ref_clk);
		miscompares++;
		final_report;
	end
endmodule
